/* File: rtl/mapr_pkg.sv */
// Package of constants shared by the memory access port register bank.
// What this block does
// - Banked word 3 starts a memory transfer at the transfer address with bits 3:0 set to 0xC.
// - Banked word 3 reads return the fetched data and writes give the memory write data.
// - Banked accesses use transfer address bits 31 to 4 and the word offset as bits 3 to 0.
// - An error response on any memory transaction is captured into the logged error flag.
// - The logged error flag reads 1 after an error since its last clear and 0 otherwise.
// - Writing 1 to the logged error flag clears it and writing 0 leaves it unchanged.
// - The response register resets to zero and its bits 31 to 1 read as zero and ignore writes.
// - The configuration incrementer field reads as 1, meaning a 10-bit address incrementer.
// - The configuration error field reads as 1: error controls and the response register exist.
// - The configuration direct window size field reads as 0xA, meaning 256 words of 32 bits.
// - The configuration register is read-only at 0x000101A0 and its reserved bits read zero.
// - The pointer address field gives the tied-off address if the present bit is 1, else zero.
// - Pointer bits 11 to 2 read as zero and ignore writes.
// - Pointer bit 1 always reads as 1.
// - Pointer bit 0 returns the tied-off component present input.
package mapr_pkg;

  localparam logic [11:0] MAPR_OFF_BANKED_WORD3  = 12'hD1C;
  localparam logic [11:0] MAPR_OFF_TRANSFER_RESP = 12'hD24;
  localparam logic [11:0] MAPR_OFF_PORT_CONFIG   = 12'hDF4;
  localparam logic [11:0] MAPR_OFF_ROM_POINTER   = 12'hDF8;

  localparam logic [31:0] MAPR_BANK_MASK         = 32'hFFFFFFF0;
  localparam logic [3:0]  MAPR_BANK3_LOW         = 4'hC;

  localparam int          MAPR_ERR_FLAG_BIT      = 0;
  localparam logic [31:0] MAPR_TRANSFER_RESP_RST = 32'h00000000;

  localparam logic [3:0]  MAPR_CFG_INC_SIZE      = 4'h1;
  localparam logic [3:0]  MAPR_CFG_ERR_MODE      = 4'h1;
  localparam logic [3:0]  MAPR_CFG_WIN_SIZE      = 4'hA;
  localparam int          MAPR_CFG_INC_LSB       = 16;
  localparam int          MAPR_CFG_ERR_LSB       = 8;
  localparam int          MAPR_CFG_WIN_LSB       = 4;
  localparam logic [31:0] MAPR_CFG_VALUE         = 32'h000101A0;

  localparam int          MAPR_PTR_ADDR_LSB      = 12;
  localparam int          MAPR_PTR_FORMAT_BIT    = 1;
  localparam int          MAPR_PTR_PRESENT_BIT   = 0;

  typedef enum logic [1:0]
  {
    MAPR_IDLE  = 2'b00,
    MAPR_SETUP = 2'b01,
    MAPR_WAIT  = 2'b10,
    MAPR_DONE  = 2'b11
  } mapr_state_type;

endpackage

/* File: rtl/mapr_sync.sv */
// Two flip-flop synchroniser for the tied-off pointer inputs.
module mapr_sync
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset.
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             clk_en_in,
  // Data.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;

  always_comb
  begin
    next_stage1 = stage1;
    next_stage2 = stage2;
    if (clk_en_in)
    begin
      next_stage1 = async_in;
      next_stage2 = stage1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync_out = stage2;

endmodule

/* File: rtl/mapr_regs.sv */
// Register bank of the memory access port: banked word 3, response, config, pointer.
module mapr_regs
(
  // Clock, reset and enable.
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  // APB slave port from the debug port.
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Transfer address from the rest of the port.
  input  wire logic [31:0] transfer_address_reg_in,
  // Memory master side.
  output logic             mem_req_out,
  output logic             mem_write_out,
  output logic      [31:0] mem_addr_out,
  output logic      [31:0] mem_wdata_out,
  input  wire logic        mem_done_in,
  input  wire logic        mem_error_in,
  input  wire logic [31:0] mem_rdata_in,
  // Logged error flag for the error controls elsewhere in the port.
  output logic             error_logged_out,
  // Tie-off pointer inputs.
  input  wire logic [19:0] base_address_in,
  input  wire logic        component_present_in
);

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic [31:0] banked_addr(input logic [31:0] transfer_address_reg, input logic [3:0] low);
    banked_addr = (transfer_address_reg & mapr_pkg::MAPR_BANK_MASK) | {28'h0000000, low};
  endfunction

  logic [19:0] base_sync;
  logic        present_sync;

  mapr_sync #(.WIDTH(21)) u_sync
  (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .async_in   ({base_address_in, component_present_in}),
    .sync_out   ({base_sync, present_sync})
  );

  //////////////////////////////////////////////////////////////////////////////

  mapr_pkg::mapr_state_type state;
  mapr_pkg::mapr_state_type next_state;
  logic        err_flag;
  logic        next_err_flag;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic        pready;
  logic        next_pready;
  logic        mem_req;
  logic        next_mem_req;
  logic        mem_write;
  logic        next_mem_write;
  logic [31:0] mem_addr;
  logic [31:0] next_mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] next_mem_wdata;

  logic        setup;
  logic        hit_bank;
  logic [31:0] read_value;
  logic        clear_err;

  always_comb
  begin
    setup     = psel_in && penable_in && (state == mapr_pkg::MAPR_IDLE);
    hit_bank  = (paddr_in == mapr_pkg::MAPR_OFF_BANKED_WORD3);
    clear_err = setup && pwrite_in && (paddr_in == mapr_pkg::MAPR_OFF_TRANSFER_RESP)
                && pwdata_in[mapr_pkg::MAPR_ERR_FLAG_BIT];
    read_value = 32'h00000000;
    case (paddr_in)
      mapr_pkg::MAPR_OFF_TRANSFER_RESP:
        read_value = {31'h0, err_flag};
      mapr_pkg::MAPR_OFF_PORT_CONFIG:
        read_value = mapr_pkg::MAPR_CFG_VALUE;
      mapr_pkg::MAPR_OFF_ROM_POINTER:
        read_value = {present_sync ? base_sync : 20'h00000,
                      10'h0, 1'b1, present_sync};
      default:
        read_value = 32'h00000000;
    endcase
  end

  // Upper bits of the response word stay zero; only bit 0 is stored.
  always_comb
  begin
    next_state     = state;
    next_err_flag  = err_flag;
    next_prdata    = prdata;
    next_pready    = 1'b0;
    next_mem_req   = 1'b0;
    next_mem_write = mem_write;
    next_mem_addr  = mem_addr;
    next_mem_wdata = mem_wdata;
    if (clear_err)
    begin
      next_err_flag = 1'b0;
    end
    if (mem_done_in && mem_error_in)
    begin
      next_err_flag = 1'b1;
    end
    case (state)
      mapr_pkg::MAPR_IDLE:
      begin
        if (setup && hit_bank)
        begin
          next_mem_req   = 1'b1;
          next_mem_write = pwrite_in;
          next_mem_addr  = banked_addr(transfer_address_reg_in,
                                       mapr_pkg::MAPR_BANK3_LOW);
          next_mem_wdata = pwdata_in;
          next_state     = mapr_pkg::MAPR_WAIT;
        end
        else if (setup)
        begin
          // Read-only registers take writes silently to keep debuggers simple.
          next_prdata = pwrite_in ? prdata : read_value;
          next_pready = 1'b1;
          next_state  = mapr_pkg::MAPR_DONE;
        end
      end
      mapr_pkg::MAPR_WAIT:
      begin
        if (mem_done_in)
        begin
          next_prdata = mem_write ? prdata : mem_rdata_in;
          next_pready = 1'b1;
          next_state  = mapr_pkg::MAPR_DONE;
        end
      end
      mapr_pkg::MAPR_DONE:
        next_state = mapr_pkg::MAPR_IDLE;
      default:
        next_state = mapr_pkg::MAPR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state     <= mapr_pkg::MAPR_IDLE;
      err_flag  <= mapr_pkg::MAPR_TRANSFER_RESP_RST[0];
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      mem_req   <= 1'b0;
      mem_write <= 1'b0;
      mem_addr  <= 32'h00000000;
      mem_wdata <= 32'h00000000;
    end
    else if (clk_en_in)
    begin
      state     <= next_state;
      err_flag  <= next_err_flag;
      prdata    <= next_prdata;
      pready    <= next_pready;
      mem_req   <= next_mem_req;
      mem_write <= next_mem_write;
      mem_addr  <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

  assign prdata_out       = prdata;
  assign pready_out       = pready;
  assign pslverr_out      = 1'b0;
  assign mem_req_out      = mem_req;
  assign mem_write_out    = mem_write;
  assign mem_addr_out     = mem_addr;
  assign mem_wdata_out    = mem_wdata;
  assign error_logged_out = err_flag;

  //////////////////////////////////////////////////////////////////////////////

  sequence s_bank_setup;
    psel_in && penable_in && state == mapr_pkg::MAPR_IDLE
      && paddr_in == mapr_pkg::MAPR_OFF_BANKED_WORD3;
  endsequence

  property p_bank_req;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (clk_en_in and s_bank_setup) |=> mem_req_out
      && mem_addr_out == (($past(transfer_address_reg_in) & 32'hFFFFFFF0) | 32'h0000000C);
  endproperty
  a_bank_req: assert property (p_bank_req) else $error("banked request wrong");

  property p_addr_low;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    mem_req_out |-> mem_addr_out[3:0] == 4'hC;
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("banked low bits wrong");

  property p_wdata;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    ((clk_en_in && pwrite_in) and s_bank_setup)
      |=> mem_write_out && mem_wdata_out == $past(pwdata_in);
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data not passed");

  property p_rdata;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && state == mapr_pkg::MAPR_WAIT && mem_done_in && !mem_write
      |=> pready_out && prdata_out == $past(mem_rdata_in);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not returned");

  property p_err_set;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && mem_done_in && mem_error_in |=> error_logged_out;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error not logged");

  property p_err_clear;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && clear_err && !(mem_done_in && mem_error_in) |=> !error_logged_out;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");

  property p_err_hold;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !clear_err && error_logged_out |=> error_logged_out;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag lost");

  property p_cfg_read;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && setup && !pwrite_in && paddr_in == mapr_pkg::MAPR_OFF_PORT_CONFIG
      |=> prdata_out == 32'h000101A0 && pready_out;
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config value wrong");

  property p_ptr_read;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && setup && !pwrite_in && paddr_in == mapr_pkg::MAPR_OFF_ROM_POINTER
      |=> prdata_out[11:1] == 11'h001 && prdata_out[0] == $past(present_sync)
        && prdata_out[31:12] == ($past(present_sync) ? $past(base_sync) : 20'h00000);
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer value wrong");

  property p_no_error;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    pready_out |-> !pslverr_out;
  endproperty
  a_no_error: assert property (p_no_error) else $error("slave error raised");

  sequence s_cfg_read;
    clk_en_in && setup && !pwrite_in && paddr_in == mapr_pkg::MAPR_OFF_PORT_CONFIG;
  endsequence

  sequence s_ptr_read;
    clk_en_in && setup && !pwrite_in && paddr_in == mapr_pkg::MAPR_OFF_ROM_POINTER;
  endsequence

  sequence s_resp_read;
    clk_en_in && setup && !pwrite_in && paddr_in == mapr_pkg::MAPR_OFF_TRANSFER_RESP;
  endsequence

  // Read-only writes are acknowledged like any other, so a debugger never sees a fault.
  sequence s_ro_write;
    clk_en_in && setup && pwrite_in && (paddr_in == mapr_pkg::MAPR_OFF_PORT_CONFIG
      || paddr_in == mapr_pkg::MAPR_OFF_ROM_POINTER);
  endsequence

  property p_cfg_inc;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    s_cfg_read |=> prdata_out[mapr_pkg::MAPR_CFG_INC_LSB +: 4] == mapr_pkg::MAPR_CFG_INC_SIZE;
  endproperty
  a_cfg_inc: assert property (p_cfg_inc) else $error("incrementer field wrong");

  property p_cfg_err;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    s_cfg_read |=> prdata_out[mapr_pkg::MAPR_CFG_ERR_LSB +: 4] == mapr_pkg::MAPR_CFG_ERR_MODE;
  endproperty
  a_cfg_err: assert property (p_cfg_err) else $error("error handling field wrong");

  property p_cfg_win;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    s_cfg_read |=> prdata_out[mapr_pkg::MAPR_CFG_WIN_LSB +: 4] == mapr_pkg::MAPR_CFG_WIN_SIZE;
  endproperty
  a_cfg_win: assert property (p_cfg_win) else $error("window size field wrong");

  property p_ptr_zero;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    s_ptr_read |=> prdata_out[11:2] == 10'h0;
  endproperty
  a_ptr_zero: assert property (p_ptr_zero) else $error("pointer reserved bits set");

  property p_ptr_format;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    s_ptr_read |=> prdata_out[mapr_pkg::MAPR_PTR_FORMAT_BIT];
  endproperty
  a_ptr_format: assert property (p_ptr_format) else $error("pointer format bit clear");

  property p_ptr_present;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    s_ptr_read |=> prdata_out[mapr_pkg::MAPR_PTR_PRESENT_BIT] == $past(present_sync);
  endproperty
  a_ptr_present: assert property (p_ptr_present) else $error("present bit wrong");

  property p_resp_read;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    s_resp_read
      |=> pready_out && prdata_out[31:1] == 31'h0 && prdata_out[0] == $past(err_flag);
  endproperty
  a_resp_read: assert property (p_resp_read) else $error("response read wrong");

  property p_ro_write;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    s_ro_write
      |=> pready_out && prdata_out == $past(prdata_out) && !mem_req_out;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write had effect");

  property p_req_pulse;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    mem_req_out |=> !mem_req_out;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request longer than a cycle");

endmodule

/* File: test/mapr_mem_model.sv */
// Behavioural memory slave that answers the register bank's transfer requests.
module mapr_mem_model
(
  // Clock and reset.
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // Request from the bank.
  input  wire logic        mem_req_in,
  input  wire logic [31:0] mem_addr_in,
  // Scenario controls.
  input  wire logic [3:0]  delay_in,
  input  wire logic        error_in,
  // Answer.
  output logic             mem_done_out,
  output logic             mem_error_out,
  output logic      [31:0] mem_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy;
  logic [3:0] cnt;
  // Read data toggles outside the done cycle so a stale capture shows up.
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      busy          <= 1'b0;
      cnt           <= 4'h0;
      mem_done_out  <= 1'b0;
      mem_error_out <= 1'b0;
      mem_rdata_out <= 32'h00000000;
    end
    else
    begin
      mem_done_out  <= 1'b0;
      mem_error_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      if (mem_req_in)
      begin
        busy <= 1'b1;
        cnt  <= delay_in;
      end
      else if (busy && cnt == 4'h0)
      begin
        busy          <= 1'b0;
        mem_done_out  <= 1'b1;
        mem_error_out <= error_in;
        mem_rdata_out <= ~mem_addr_in;
      end
      else if (busy)
        cnt <= cnt - 4'h1;
    end
  end
endmodule

/* File: test/mapr_regs_tb_top.sv */
// Self-checking testbench of the memory access port register bank.
module mapr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] transfer_address_reg = 32'h00000000;
  logic [19:0] base = 20'h00000;
  logic        present = 1'b0;
  logic [3:0]  delay = 4'h0;
  logic        err = 1'b0;
  logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, q;
  logic        pready, pslverr, mem_req, mem_write, mem_done, mem_error, err_log;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          n_req = 0;
  always #5 clk = ~clk;
  // Counts request pulses so a repeated or lost transfer shows up.
  always @(posedge clk)
    if (mem_req === 1'b1)
      n_req++;
  mapr_regs i_dut (.sys_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .transfer_address_reg_in(transfer_address_reg), .mem_req_out(mem_req), .mem_write_out(mem_write),
    .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_done_in(mem_done),
    .mem_error_in(mem_error), .mem_rdata_in(mem_rdata), .error_logged_out(err_log),
    .base_address_in(base), .component_present_in(present));
  mapr_mem_model i_mem (.sys_clk_in(clk), .reset_n_in(rst_n), .mem_req_in(mem_req),
    .mem_addr_in(mem_addr), .delay_in(delay), .error_in(err), .mem_done_out(mem_done),
    .mem_error_out(mem_error), .mem_rdata_out(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Request is held until the edge that samples pready high, then released.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #1 psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(posedge clk);
    #1 penable = 1'b1;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (pready !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      n_mismatch++;
      summarize();
    end
    q = prdata;
    check("pslverr", {31'h0, pslverr}, 32'h0);
    @(posedge clk);
    #1 psel = 1'b0;
    penable = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_fixed();
    apb(1'b0, 12'hD24, 32'h0);
    check("resp reset", q, 32'h00000000);
    apb(1'b1, 12'hDF4, 32'hFFFFFFFF);
    apb(1'b0, 12'hDF4, 32'h0);
    check("config", q, 32'h000101A0);
    apb(1'b0, 12'hE00, 32'h0);
    check("unmapped", q, 32'h00000000);
  endtask
  task automatic t_pointer();
    base = 20'hABCDE;
    present = 1'b1;
    apb(1'b1, 12'hDF8, 32'hFFFFFFFF);
    apb(1'b0, 12'hDF8, 32'h0);
    check("pointer on", q, 32'hABCDE003);
    present = 1'b0;
    apb(1'b0, 12'hDF8, 32'h0);
    check("pointer off", q, 32'h00000002);
  endtask
  // Bank word 3 across low-nibble corners of the transfer address.
  task automatic t_bank();
    logic [31:0] tars [3] = '{32'h12345677, 32'hFFFFFFF0, 32'h0000000F};
    foreach (tars[i])
    begin
      transfer_address_reg = tars[i];
      delay = 4'(i * 5);
      apb(1'b0, 12'hD1C, 32'h0);
      check("bank rd addr", mem_addr, (tars[i] & 32'hFFFFFFF0) | 32'hC);
      check("bank rd dir", {31'h0, mem_write}, 32'h0);
      check("bank rd data", q, ~((tars[i] & 32'hFFFFFFF0) | 32'hC));
      apb(1'b1, 12'hD1C, 32'hA5A55A5A ^ tars[i]);
      check("bank wr dir", {31'h0, mem_write}, 32'h1);
      check("bank wr data", mem_wdata, 32'hA5A55A5A ^ tars[i]);
    end
    check("request count", n_req, 32'h00000006);
  endtask
  task automatic t_error();
    err = 1'b1;
    apb(1'b0, 12'hD1C, 32'h0);
    err = 1'b0;
    check("flag out", {31'h0, err_log}, 32'h1);
    check("request count err", n_req, 32'h00000007);
    apb(1'b1, 12'hD24, 32'hFFFFFFFE);
    apb(1'b0, 12'hD24, 32'h0);
    check("flag kept", q, 32'h00000001);
    apb(1'b1, 12'hD24, 32'h00000001);
    apb(1'b0, 12'hD24, 32'h0);
    check("flag clear", q, 32'h00000000);
    check("flag out clr", {31'h0, err_log}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    t_fixed();
    t_pointer();
    t_bank();
    t_error();
    summarize();
  end
endmodule
